// ===== verilog/tpg_defs.svh
// Register offsets, colour values and packet codes for the test pattern source
`ifndef TPG_DEFS_SVH
`define TPG_DEFS_SVH
`define TPG_REG_GO 3'h0
`define TPG_REG_STATUS 3'h1
`define TPG_REG_WIDTH 3'h2
`define TPG_REG_HEIGHT 3'h3
`define TPG_GO_RST 1'h0
`define TPG_RGB_ON 8'hb4
`define TPG_RGB_OFF 8'h10
`define TPG_YCC_WHITE 24'hb48080
`define TPG_YCC_YELLOW 24'ha22c8e
`define TPG_YCC_CYAN 24'h839c2c
`define TPG_YCC_GREEN 24'h70483a
`define TPG_YCC_MAGENTA 24'h54b8c6
`define TPG_YCC_RED 24'h4164d4
`define TPG_YCC_BLUE 24'h23d472
`define TPG_YCC_BLACK 24'h108080
`define TPG_RGB_BLACK 24'h101010
`define TPG_PKT_CTRL 4'hf
`define TPG_PKT_IMG 4'h0
`define TPG_CTRL_LAST 2'h2
`define TPG_BAR_LAST 3'h7
`define TPG_IL_INTERLACED 4'h8
`define TPG_IL_PROGRESSIVE 4'h0
`define TPG_BORDER_NARROW 16'h0001
`define TPG_BORDER_WIDE 16'h0002
`endif

// ===== verilog/tpg_pkg.sv
// Types shared by the test pattern source
package tpg_pkg;
	typedef enum logic [7:0] {
		ST_IDLE = 8'h01,
		ST_LOAD = 8'h02,
		ST_CALC = 8'h04,
		ST_CHDR = 8'h08,
		ST_CBODY = 8'h10,
		ST_IHDR = 8'h20,
		ST_PIX = 8'h40,
		ST_SPARE = 8'h80
	} tpg_state_t;
	typedef enum logic [1:0] {
		SS_444 = 2'h0,
		SS_422 = 2'h1,
		SS_420 = 2'h2
	} tpg_subsamp_t;
endpackage

// ===== verilog/tpg_top.sv
// Video test pattern source with control packets and register control
`timescale 1ns/1ps
`include "tpg_defs.svh"

module tpg_top #(
	parameter int BPS = 8,
	parameter int MAX_W = 640,
	parameter int MAX_H = 480,
	parameter bit YCBCR = 1'b0,
	parameter logic [1:0] SUBSAMP = 2'h0,
	parameter bit INTERLACED = 1'b0,
	parameter bit F1_SYNC = 1'b1,
	parameter bit UNIFORM = 1'b0,
	parameter logic [23:0] UNIFORM_COLOR = 24'h808080,
	parameter bit RUNTIME_CTRL = 1'b1
) (
	// Clock and reset
	input wire logic CLK_I,
	input wire logic RESETN_I,
	// Register port
	input wire logic [2:0] REG_ADDR_I,
	input wire logic [31:0] REG_WDATA_I,
	input wire logic REG_WR_I,
	input wire logic REG_RD_I,
	output logic [31:0] REG_RDATA_O,
	// Video stream
	output logic [3*BPS-1:0] VID_DATA_O,
	output logic VID_VALID_O,
	output logic VID_SOP_O,
	output logic VID_EOP_O,
	input wire logic VID_READY_I
);
	localparam int DW = 3 * BPS;
	localparam bit HSUB = YCBCR && (SUBSAMP != 2'h0);
	localparam bit VSUB = YCBCR && (SUBSAMP == 2'h2);

	// Build-time legality
	generate
		if (!YCBCR && SUBSAMP != 2'h0) begin : g_bad_rgb
			$error("RGB output needs 4:4:4 sampling");
		end
		if (SUBSAMP == 2'h2 && INTERLACED) begin : g_bad_vsub
			$error("Vertical subsampling and interlace are exclusive");
		end
		if (SUBSAMP > 2'h2) begin : g_bad_ss
			$error("Unknown subsampling code");
		end
		if (BPS < 4 || BPS > 16) begin : g_bad_bps
			$error("Sample width must be 4 to 16 bits");
		end
		if (MAX_W < 16 || MAX_W > 65535 || MAX_H < 4 || MAX_H > 65535) begin : g_bad_res
			$error("Resolution out of range");
		end
		if ((INTERLACED || VSUB) && (MAX_H % 2 != 0)) begin : g_bad_odd
			$error("Height must be even with interlace or vertical subsampling");
		end
	endgenerate

	// Scale an 8-bit value to the sample width
	function automatic logic [BPS-1:0] scale8(input logic [7:0] v);
		logic [23:0] t;
		t = {v, 16'h0000};
		return t[23 -: BPS];
	endfunction

	// Place a nibble in the low bits of a symbol
	function automatic logic [BPS-1:0] nib(input logic [3:0] v);
		logic [BPS-1:0] s;
		s = '0;
		s[3:0] = v;
		return s;
	endfunction

	// Bar colour lookup, YCbCr as {Y,Cb,Cr}, RGB as {R,G,B}
	function automatic logic [23:0] bar_color(input logic [2:0] bar);
		logic [23:0] c;
		c = `TPG_YCC_BLACK;
		if (YCBCR) begin
			case (bar)
				3'h0: c = `TPG_YCC_WHITE;
				3'h1: c = `TPG_YCC_YELLOW;
				3'h2: c = `TPG_YCC_CYAN;
				3'h3: c = `TPG_YCC_GREEN;
				3'h4: c = `TPG_YCC_MAGENTA;
				3'h5: c = `TPG_YCC_RED;
				3'h6: c = `TPG_YCC_BLUE;
				default: c = `TPG_YCC_BLACK;
			endcase
		end else begin
			c[23:16] = bar[1] ? `TPG_RGB_OFF : `TPG_RGB_ON;
			c[15:8] = bar[2] ? `TPG_RGB_OFF : `TPG_RGB_ON;
			c[7:0] = bar[0] ? `TPG_RGB_OFF : `TPG_RGB_ON;
		end
		return c;
	endfunction

	// Pack a colour into the output beat
	function automatic logic [DW-1:0] pack(input logic [23:0] c, input logic odd);
		logic [DW-1:0] d;
		d = '0;
		if (!YCBCR) begin
			d = {scale8(c[23:16]), scale8(c[15:8]), scale8(c[7:0])};
		end else if (!HSUB) begin
			d = {scale8(c[7:0]), scale8(c[15:8]), scale8(c[23:16])};
		end else begin
			d[2*BPS-1:BPS] = odd ? scale8(c[7:0]) : scale8(c[15:8]);
			d[BPS-1:0] = scale8(c[23:16]);
		end
		return d;
	endfunction

	tpg_pkg::tpg_state_t state_q;
	logic go_q;
	logic status_q;
	logic [15:0] width_q;
	logic [15:0] height_q;
	logic [31:0] rdata_q;
	logic [15:0] w_q;
	logic [15:0] h_q;
	logic [15:0] lh_q;
	logic [15:0] bx_q;
	logic [15:0] by_q;
	logic [15:0] bar_w_q;
	logic [15:0] x_q;
	logic [15:0] y_q;
	logic [15:0] cnt_q;
	logic [2:0] bar_q;
	logic [1:0] cb_q;
	logic field_q;
	logic first_q;
	logic [DW-1:0] data_q;
	logic valid_q;
	logic sop_q;
	logic eop_q;
	logic adv;
	logic go_eff;
	logic border;
	logic last_x;
	logic last_y;
	logic [23:0] pix_c;
	logic [3:0] il_nib;
	logic [15:0] iw;
	logic [15:0] bw_raw;
	logic [3:0] nibs [0:8];

	assign adv = !valid_q || VID_READY_I;
	assign go_eff = RUNTIME_CTRL ? go_q : 1'b1;
	assign last_x = (x_q == w_q - 16'h0001);
	assign last_y = (y_q == lh_q - 16'h0001);

	// Register writes
	always_ff @(posedge CLK_I) begin
		if (!RESETN_I) begin
			go_q <= `TPG_GO_RST;
			width_q <= 16'(MAX_W);
			height_q <= 16'(MAX_H);
		end else if (REG_WR_I) begin
			case (REG_ADDR_I)
				`TPG_REG_GO: go_q <= REG_WDATA_I[0];
				`TPG_REG_WIDTH: width_q <= REG_WDATA_I[15:0];
				`TPG_REG_HEIGHT: height_q <= REG_WDATA_I[15:0];
				default: ;
			endcase
		end
	end

	// Read data stands for one cycle after the strobe
	always_ff @(posedge CLK_I) begin
		if (!RESETN_I) begin
			rdata_q <= 32'h00000000;
		end else if (REG_RD_I) begin
			case (REG_ADDR_I)
				`TPG_REG_GO: rdata_q <= {31'h00000000, go_q};
				`TPG_REG_STATUS: rdata_q <= {31'h00000000, status_q};
				`TPG_REG_WIDTH: rdata_q <= {16'h0000, width_q};
				`TPG_REG_HEIGHT: rdata_q <= {16'h0000, height_q};
				default: rdata_q <= 32'h00000000;
			endcase
		end else begin
			rdata_q <= 32'h00000000;
		end
	end

	// Geometry of the frame being loaded
	always_comb begin
		iw = w_q - (bx_q << 1);
		bw_raw = iw >> 3;
		if (HSUB) begin
			bw_raw = {bw_raw[15:1], 1'b0};
		end
	end

	// Control packet symbols: width, height, then interlace nibble
	always_comb begin
		il_nib = INTERLACED ? (`TPG_IL_INTERLACED | {1'b0, field_q, 1'b0, F1_SYNC}) :
			`TPG_IL_PROGRESSIVE;
		nibs[0] = w_q[15:12];
		nibs[1] = w_q[11:8];
		nibs[2] = w_q[7:4];
		nibs[3] = w_q[3:0];
		nibs[4] = lh_q[15:12];
		nibs[5] = lh_q[11:8];
		nibs[6] = lh_q[7:4];
		nibs[7] = lh_q[3:0];
		nibs[8] = il_nib;
	end

	// Pixel colour with border
	always_comb begin
		border = (x_q < bx_q) || (x_q >= w_q - bx_q) ||
			(y_q < by_q) || (y_q >= lh_q - by_q);
		pix_c = UNIFORM ? UNIFORM_COLOR : bar_color(bar_q);
		if (border) begin
			pix_c = YCBCR ? `TPG_YCC_BLACK : `TPG_RGB_BLACK;
		end
	end

	// Frame sequencer and stream output
	always_ff @(posedge CLK_I) begin
		if (!RESETN_I) begin
			state_q <= tpg_pkg::ST_IDLE;
			status_q <= 1'b0;
			w_q <= 16'(MAX_W);
			h_q <= 16'(MAX_H);
			lh_q <= 16'(MAX_H);
			bx_q <= `TPG_BORDER_NARROW;
			by_q <= `TPG_BORDER_NARROW;
			bar_w_q <= 16'h0000;
			x_q <= 16'h0000;
			y_q <= 16'h0000;
			cnt_q <= 16'h0000;
			bar_q <= 3'h0;
			cb_q <= 2'h0;
			field_q <= 1'b0;
			first_q <= 1'b0;
			data_q <= '0;
			valid_q <= 1'b0;
			sop_q <= 1'b0;
			eop_q <= 1'b0;
		end else begin
			if (adv) begin
				valid_q <= 1'b0;
				sop_q <= 1'b0;
				eop_q <= 1'b0;
			end
			case (state_q)
				tpg_pkg::ST_IDLE: begin
					status_q <= 1'b0;
					if (go_eff) begin
						state_q <= tpg_pkg::ST_LOAD;
					end
				end
				tpg_pkg::ST_LOAD: begin
					w_q <= RUNTIME_CTRL ? width_q : 16'(MAX_W);
					h_q <= RUNTIME_CTRL ? height_q : 16'(MAX_H);
					bx_q <= HSUB ? `TPG_BORDER_WIDE : `TPG_BORDER_NARROW;
					by_q <= VSUB ? `TPG_BORDER_WIDE : `TPG_BORDER_NARROW;
					field_q <= !F1_SYNC;
					first_q <= 1'b1;
					status_q <= 1'b1;
					state_q <= tpg_pkg::ST_CALC;
				end
				tpg_pkg::ST_CALC: begin
					lh_q <= INTERLACED ? (h_q >> 1) : h_q;
					bar_w_q <= bw_raw;
					state_q <= tpg_pkg::ST_CHDR;
				end
				tpg_pkg::ST_CHDR: begin
					if (adv) begin
						data_q <= {{(DW-4){1'b0}}, `TPG_PKT_CTRL};
						valid_q <= 1'b1;
						sop_q <= 1'b1;
						cb_q <= 2'h0;
						state_q <= tpg_pkg::ST_CBODY;
					end
				end
				tpg_pkg::ST_CBODY: begin
					if (adv) begin
						data_q <= {nib(nibs[3*cb_q+2]), nib(nibs[3*cb_q+1]),
							nib(nibs[3*cb_q])};
						valid_q <= 1'b1;
						eop_q <= (cb_q == `TPG_CTRL_LAST);
						cb_q <= cb_q + 2'h1;
						if (cb_q == `TPG_CTRL_LAST) begin
							state_q <= tpg_pkg::ST_IHDR;
						end
					end
				end
				tpg_pkg::ST_IHDR: begin
					if (adv) begin
						data_q <= {{(DW-4){1'b0}}, `TPG_PKT_IMG};
						valid_q <= 1'b1;
						sop_q <= 1'b1;
						x_q <= 16'h0000;
						y_q <= 16'h0000;
						cnt_q <= 16'h0000;
						bar_q <= 3'h0;
						state_q <= tpg_pkg::ST_PIX;
					end
				end
				tpg_pkg::ST_PIX: begin
					if (adv) begin
						data_q <= pack(pix_c, x_q[0]);
						valid_q <= 1'b1;
						eop_q <= last_x && last_y;
						if (x_q >= bx_q) begin
							if (cnt_q == bar_w_q - 16'h0001 && bar_q != `TPG_BAR_LAST) begin
								bar_q <= bar_q + 3'h1;
								cnt_q <= 16'h0000;
							end else begin
								cnt_q <= cnt_q + 16'h0001;
							end
						end
						if (last_x) begin
							x_q <= 16'h0000;
							y_q <= y_q + 16'h0001;
							cnt_q <= 16'h0000;
							bar_q <= 3'h0;
						end else begin
							x_q <= x_q + 16'h0001;
						end
						if (last_x && last_y) begin
							if (INTERLACED && first_q) begin
								first_q <= 1'b0;
								field_q <= !field_q;
								state_q <= tpg_pkg::ST_CHDR;
							end else begin
								state_q <= tpg_pkg::ST_IDLE;
							end
						end
					end
				end
				default: begin
					state_q <= tpg_pkg::ST_IDLE;
				end
			endcase
		end
	end

	assign REG_RDATA_O = rdata_q;
	assign VID_DATA_O = data_q;
	assign VID_VALID_O = valid_q;
	assign VID_SOP_O = sop_q;
	assign VID_EOP_O = eop_q;
endmodule

// ===== bench/tpg_top_sva.sv
// Checker for the stream and register port of the test pattern source
`timescale 1ns/1ps
module tpg_top_sva #(
	parameter int BPS = 8
) (
	// Clock and reset
	input wire logic CLK_I,
	input wire logic RESETN_I,
	// Register port
	input wire logic [2:0] REG_ADDR_I,
	input wire logic [31:0] REG_WDATA_I,
	input wire logic REG_WR_I,
	input wire logic REG_RD_I,
	input wire logic [31:0] REG_RDATA_O,
	// Video stream
	input wire logic [3*BPS-1:0] VID_DATA_O,
	input wire logic VID_VALID_O,
	input wire logic VID_SOP_O,
	input wire logic VID_EOP_O,
	input wire logic VID_READY_I
);
	default clocking @(posedge CLK_I); endclocking
	default disable iff (!RESETN_I);
	beat_hold_a: assert property (
		VID_VALID_O && !VID_READY_I |=> VID_VALID_O && $stable(VID_DATA_O)
			&& $stable(VID_SOP_O) && $stable(VID_EOP_O))
		else $error("beat changed while stalled");
	mark_valid_a: assert property ((VID_SOP_O || VID_EOP_O) |-> VID_VALID_O)
		else $error("packet mark without valid");
	no_gap_a: assert property (
		VID_VALID_O && VID_READY_I && !VID_EOP_O |=> VID_VALID_O)
		else $error("gap inside packet");
	sop_once_a: assert property (
		VID_VALID_O && VID_READY_I && VID_SOP_O |=> !(VID_VALID_O && VID_SOP_O))
		else $error("two start beats in a row");
	eop_once_a: assert property (
		VID_VALID_O && VID_READY_I && VID_EOP_O |=> !(VID_VALID_O && VID_EOP_O))
		else $error("two end beats in a row");
	rdata_idle_a: assert property (!$past(REG_RD_I) |-> REG_RDATA_O == 32'h0)
		else $error("read data outside read slot");
	unmapped_read_a: assert property (REG_RD_I && REG_ADDR_I[2] |=> REG_RDATA_O == 32'h0)
		else $error("unmapped read not zero");
	status_bits_a: assert property (
		REG_RD_I && REG_ADDR_I == 3'h1 |=> REG_RDATA_O[31:1] == 31'h0)
		else $error("status upper bits set");
	reset_idle_a: assert property (
		$rose(RESETN_I) |-> !VID_VALID_O && REG_RDATA_O == 32'h0)
		else $error("outputs busy after reset");
endmodule

bind tpg_top tpg_top_sva #(.BPS(BPS)) tpg_top_sva_i (.CLK_I(CLK_I), .RESETN_I(RESETN_I),
	.REG_ADDR_I(REG_ADDR_I), .REG_WDATA_I(REG_WDATA_I), .REG_WR_I(REG_WR_I),
	.REG_RD_I(REG_RD_I), .REG_RDATA_O(REG_RDATA_O), .VID_DATA_O(VID_DATA_O),
	.VID_VALID_O(VID_VALID_O), .VID_SOP_O(VID_SOP_O), .VID_EOP_O(VID_EOP_O),
	.VID_READY_I(VID_READY_I));

// ===== bench/tpg_sink.sv
// Downstream stream sink that applies random back-pressure
`timescale 1ns/1ps
module tpg_sink (
	// Clock and control
	input wire logic clk_i,
	input wire logic stall_en_i,
	// Stream handshake
	output logic ready_o = 1'b1
);
	integer seed = 32'haf99cd9a;
	always @(posedge clk_i) begin
		ready_o <= !stall_en_i || (($random(seed) & 32'h3) != 0);
	end
endmodule

// ===== bench/test_video_test_pattern_source.sv
// Self-checking bench for the test pattern source
`timescale 1ns/1ps
module test_video_test_pattern_source;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [2:0] addr = 3'h0;
	logic [31:0] wdata = 32'h0;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic stall_en = 1'b0;
	logic [31:0] rdata;
	logic [23:0] vdata;
	logic vvalid, vsop, veop, vready;
	logic [25:0] e;
	logic [25:0] expq[$];
	logic [29:0] vdata2;
	logic vvalid2, vsop2, veop2, vready2;
	logic [31:0] e2;
	logic [31:0] expq2[$];
	logic [23:0] ycc_tab [8] = '{24'hb48080, 24'ha22c8e, 24'h839c2c, 24'h70483a,
		24'h54b8c6, 24'h4164d4, 24'h23d472, 24'h108080};
	int mismatches = 0;
	int n_compared = 0;
	always #5 clk = ~clk;
	tpg_top #(.MAX_W(20), .MAX_H(4)) tpg_top_i (.CLK_I(clk), .RESETN_I(rst_n),
		.REG_ADDR_I(addr), .REG_WDATA_I(wdata), .REG_WR_I(wr), .REG_RD_I(rd),
		.REG_RDATA_O(rdata), .VID_DATA_O(vdata), .VID_VALID_O(vvalid),
		.VID_SOP_O(vsop), .VID_EOP_O(veop), .VID_READY_I(vready));
	tpg_sink tpg_sink_i (.clk_i(clk), .stall_en_i(stall_en), .ready_o(vready));
	// YCbCr 4:2:2 interlaced build with 10-bit samples and fixed resolution
	if (1) begin : g_ycc
		tpg_top #(.BPS(10), .MAX_W(28), .MAX_H(8), .YCBCR(1'b1), .SUBSAMP(2'h1),
			.INTERLACED(1'b1), .RUNTIME_CTRL(1'b0)) tpg_top_i (.CLK_I(clk),
			.RESETN_I(rst_n), .REG_ADDR_I(addr), .REG_WDATA_I(wdata), .REG_WR_I(wr),
			.REG_RD_I(rd), .REG_RDATA_O(), .VID_DATA_O(vdata2), .VID_VALID_O(vvalid2),
			.VID_SOP_O(vsop2), .VID_EOP_O(veop2), .VID_READY_I(vready2));
		tpg_sink tpg_sink_i (.clk_i(clk), .stall_en_i(stall_en), .ready_o(vready2));
	end
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			mismatches++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic reg_wr(input logic [2:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic reg_rd(input logic [2:0] a, output logic [31:0] d);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 d = rdata;
	endtask
	// Bar colour model: green first four, red per two, blue per bar
	function automatic logic [23:0] pix(int x, int y, int w, int h);
		int b;
		if (x == 0 || x == w - 1 || y == 0 || y == h - 1) return 24'h101010;
		b = (x - 1) / ((w - 2) / 8);
		if (b > 7) b = 7;
		return {(b % 4 < 2) ? 8'hb4 : 8'h10, (b < 4) ? 8'hb4 : 8'h10,
			(b % 2 == 0) ? 8'hb4 : 8'h10};
	endfunction
	// 4:2:2 beat: two-pixel side borders, even bar width, 8-bit values padded to 10
	function automatic logic [29:0] ypix(int x, int y, int w, int h);
		logic [23:0] c;
		int b;
		c = 24'h108080;
		if (x >= 2 && x < w - 2 && y > 0 && y < h - 1) begin
			b = (x - 2) / ((w - 4) / 16 * 2);
			c = ycc_tab[(b > 7) ? 7 : b];
		end
		return {10'h000, (x % 2 == 1) ? c[7:0] : c[15:8], 2'b00, c[23:16], 2'b00};
	endfunction
	// Queue one field of the 10-bit build as {sop, eop, data} beats
	task automatic field2(input logic [15:0] w, input logic [15:0] lh, input logic [3:0] il);
		expq2.push_back({2'b10, 30'h0000000f});
		expq2.push_back({2'b00, 6'h00, w[7:4], 6'h00, w[11:8], 6'h00, w[15:12]});
		expq2.push_back({2'b00, 6'h00, lh[11:8], 6'h00, lh[15:12], 6'h00, w[3:0]});
		expq2.push_back({2'b01, 6'h00, il, 6'h00, lh[3:0], 6'h00, lh[7:4]});
		expq2.push_back({2'b10, 30'h00000000});
		for (int y = 0; y < lh; y++) begin
			for (int x = 0; x < w; x++) begin
				expq2.push_back({1'b0, (x == w - 1 && y == lh - 1), ypix(x, y, w, lh)});
			end
		end
	endtask
	// Queue one frame as {sop, eop, data} beats
	task automatic frame(input logic [15:0] w, input logic [15:0] h);
		expq.push_back({2'b10, 24'h00000f});
		expq.push_back({2'b00, 4'h0, w[7:4], 4'h0, w[11:8], 4'h0, w[15:12]});
		expq.push_back({2'b00, 4'h0, h[11:8], 4'h0, h[15:12], 4'h0, w[3:0]});
		expq.push_back({2'b01, 8'h00, 4'h0, h[3:0], 4'h0, h[7:4]});
		expq.push_back({2'b10, 24'h000000});
		for (int y = 0; y < h; y++) begin
			for (int x = 0; x < w; x++) begin
				expq.push_back({1'b0, (x == w - 1 && y == h - 1), pix(x, y, w, h)});
			end
		end
	endtask
	always @(posedge clk) begin
		if (rst_n && vvalid && vready && expq.size() > 0) begin
			e = expq.pop_front();
			check({6'h0, vsop, veop, vdata}, {6'h0, e});
		end
	end
	always @(posedge clk) begin
		if (rst_n && vvalid2 && vready2 && expq2.size() > 0) begin
			e2 = expq2.pop_front();
			check({vsop2, veop2, vdata2}, e2);
		end
	end
	task automatic print_verdict;
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge clk);
		mismatches++;
		$display("[ERR] %0t timeout", $time);
		print_verdict;
	end
	initial begin
		logic [31:0] d;
		int k;
		field2(16'd28, 16'd4, 4'h9);
		field2(16'd28, 16'd4, 4'hd);
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		reg_rd(3'h2, d);
		check(d, 32'd20);
		reg_rd(3'h3, d);
		check(d, 32'd4);
		reg_rd(3'h1, d);
		check(d, 32'h0);
		reg_rd(3'h5, d);
		check(d, 32'h0);
		reg_wr(3'h1, 32'h1);
		reg_rd(3'h1, d);
		check(d, 32'h0);
		frame(16'd20, 16'd4);
		frame(16'd18, 16'd4);
		stall_en <= 1'b1;
		reg_wr(3'h0, 32'h1);
		repeat (10) @(posedge clk);
		reg_wr(3'h2, 32'd18);
		reg_rd(3'h1, d);
		check(d, 32'h1);
		k = 0;
		while ((expq.size() > 0 || expq2.size() > 0) && k < 5000) begin
			@(posedge clk);
			k++;
		end
		check(k < 5000, 1'b1);
		reg_wr(3'h0, 32'h0);
		k = 0;
		d = 32'h1;
		while (d !== 32'h0 && k < 500) begin
			reg_rd(3'h1, d);
			k++;
		end
		check(d, 32'h0);
		print_verdict;
	end
endmodule
